// File: rtl/pls_array.sv
`timescale 1ns/10ps
`include "pls_regs.svh"
module pls_array (
   input  pls_pkg::pls_term_t terms [`PLS_NUM_TERMS],
   input  pls_pkg::pls_vars_t vars,
   input  logic               drop_in16,
   input  logic [7:0]         state,
   input  logic [7:0]         out_reg,
   output logic [7:0]         next_state,
   output logic [7:0]         next_out,
   output logic [3:0]         ctl_hits
);
   import pls_pkg::*;

   logic [`PLS_NUM_TERMS-1:0] pass1;
   logic [`PLS_NUM_TERMS-1:0] hit;
   logic                      cbit;
   pls_vars_t                 tl;
   pls_vars_t                 cl;
   pls_vars_t                 v;
   logic [7:0]                js;
   logic [7:0]                ks;
   logic [7:0]                jo;
   logic [7:0]                ko;

   always_comb begin
      pass1 = '0;
      hit   = '0;
      tl    = '0;
      cl    = '0;
      v     = vars;
      js    = '0;
      ks    = '0;
      jo    = '0;
      ko    = '0;
      // First pass ignores the complement variable to form it
      for (int i = 0; i < `PLS_NUM_TERMS; i++) begin
         tl = terms[i].t;
         cl = terms[i].c;
         if (drop_in16) begin
            tl.in[16] = 1'b0;
            cl.in[16] = 1'b0;
         end
         tl.c = 1'b0;
         cl.c = 1'b0;
         pass1[i] = pls_hit(tl, cl, v);
      end
      cbit = 1'b1;
      for (int i = 0; i < `PLS_NUM_TERMS; i++) begin
         if (terms[i].feeds_c && pass1[i]) begin
            cbit = 1'b0;
         end
      end
      // Second pass through the AND array with the complement fed back
      v.c = cbit;
      for (int i = 0; i < `PLS_NUM_TERMS; i++) begin
         tl = terms[i].t;
         cl = terms[i].c;
         if (drop_in16) begin
            tl.in[16] = 1'b0;
            cl.in[16] = 1'b0;
         end
         hit[i] = pls_hit(tl, cl, v);
      end
      for (int i = 0; i < `PLS_TERM_INA; i++) begin
         if (hit[i]) begin
            js = js | terms[i].j_st;
            ks = ks | terms[i].k_st;
            jo = jo | terms[i].j_out;
            ko = ko | terms[i].k_out;
         end
      end
      for (int b = 0; b < 8; b++) begin
         next_state[b] = pls_jk(state[b], js[b], ks[b]);
         next_out[b]   = pls_jk(out_reg[b], jo[b], ko[b]);
      end
      ctl_hits = hit[`PLS_TERM_OEB:`PLS_TERM_INA];
   end
endmodule

// File: rtl/pls_core.sv
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "pls_regs.svh"
module pls_core (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire pls_pkg::pls_apb_req_t apb,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [15:0]           logic_in,
   input  wire logic                  seq_clk,
   input  wire logic                  ctl_pin,
   input  wire logic                  sv_diag_show,
   input  wire logic                  sv_load_state,
   input  wire logic                  sv_load_out,
   input  wire logic [7:0]            f_in,
   output logic [7:0]                 f_out,
   output logic [7:0]                 f_oe
);
   import pls_pkg::*;

   pls_cfg_t    cfg;
   logic [15:0] preset;
   pls_term_t   terms [`PLS_NUM_TERMS];
   logic [7:0]  state;
   logic [7:0]  out_reg;
   logic [7:0]  next_state;
   logic [7:0]  next_out;
   logic [3:0]  ctl_hits;
   logic        clk_q;
   logic        clk_src;
   logic        clk_rise;
   logic        clk_fall;
   logic        pin_input;
   logic        pd_active;
   logic        pin_init;
   logic        pin_oe;
   logic [1:0]  init;
   logic [1:0]  oe_off;
   logic [1:0]  clk_valid;
   logic [1:0]  locked;
   logic        apb_done;
   logic        wr_en;
   logic [6:0]  idx;
   logic [31:0] rd_word;
   pls_vars_t   vars;

   // Sequencer clock is sampled, so edges are seen one ref_clk late
   assign clk_src   = cfg.clock_source_choice ? logic_in[5] : seq_clk;
   assign clk_rise  = clk_src & ~clk_q;
   assign clk_fall  = ~clk_src & clk_q;
   assign pin_input = (cfg.pin_mode == PLS_PIN_INPUT);
   assign pd_active = (cfg.pin_mode == PLS_PIN_PWRDN) & ctl_pin;
   assign pin_init  = (cfg.pin_mode == PLS_PIN_INIT) & ctl_pin;
   assign pin_oe    = (cfg.pin_mode == PLS_PIN_OE) & ctl_pin;
   assign vars      = '{c: 1'b0, st: state, in: {ctl_pin & pin_input, logic_in}};

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clk_q <= 1'b0;
      end else begin
         clk_q <= clk_src;
      end
   end

   pls_array u_array (
      .terms      (terms),
      .vars       (vars),
      .drop_in16  (~pin_input),
      .state      (state),
      .out_reg    (out_reg),
      .next_state (next_state),
      .next_out   (next_out),
      .ctl_hits   (ctl_hits)
   );

   // Group a: state/output bits 3:0, group b: bits 7:4
   pls_grp u_grp_a (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .pin_init     (pin_init),
      .term_init    (ctl_hits[0]),
      .term_init_en (cfg.init_term_en_a),
      .pin_oe       (pin_oe),
      .term_oe      (ctl_hits[2]),
      .term_oe_en   (cfg.oe_term_en_a),
      .clk_rise     (clk_rise),
      .clk_fall     (clk_fall),
      .hold         (pd_active),
      .init         (init[0]),
      .oe_off       (oe_off[0]),
      .clk_valid    (clk_valid[0]),
      .locked       (locked[0])
   );

   pls_grp u_grp_b (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .pin_init     (pin_init),
      .term_init    (ctl_hits[1]),
      .term_init_en (cfg.init_term_en_b),
      .pin_oe       (pin_oe),
      .term_oe      (ctl_hits[3]),
      .term_oe_en   (cfg.oe_term_en_b),
      .clk_rise     (clk_rise),
      .clk_fall     (clk_fall),
      .hold         (pd_active),
      .init         (init[1]),
      .oe_off       (oe_off[1]),
      .clk_valid    (clk_valid[1]),
      .locked       (locked[1])
   );

   // Sequencer registers; power down outranks init and clocking
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state   <= `PLS_REGS_RST;
         out_reg <= `PLS_REGS_RST;
      end else if (!pd_active) begin
         for (int g = 0; g < 2; g++) begin
            if (init[g]) begin
               state[g*4 +: 4]   <= preset[g*4 +: 4];
               out_reg[g*4 +: 4] <= preset[8+g*4 +: 4];
            end else if (clk_valid[g]) begin
               if (sv_load_state) begin
                  state[g*4 +: 4] <= f_in[g*4 +: 4];
               end else if (sv_load_out) begin
                  out_reg[g*4 +: 4] <= f_in[g*4 +: 4];
               end else begin
                  state[g*4 +: 4]   <= next_state[g*4 +: 4];
                  out_reg[g*4 +: 4] <= next_out[g*4 +: 4];
               end
            end
         end
      end
   end

   // Pin drivers; registered, so they trail the registers by one cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         f_out <= `PLS_REGS_RST;
         f_oe  <= 8'h00;
      end else begin
         f_out <= sv_diag_show ? state : out_reg;
         if (pd_active || sv_load_state || sv_load_out) begin
            f_oe <= 8'h00;
         end else begin
            f_oe <= {{4{~oe_off[1]}}, {4{~oe_off[0]}}};
         end
      end
   end

   // APB slave: one wait state, pready from a flop
   assign apb_done = apb.psel & apb.penable & pready;
   assign wr_en    = apb_done & apb.pwrite & pls_addr_ok(apb.paddr);
   assign idx      = pls_term_idx(apb.paddr);

   always_comb begin
      rd_word = 32'h0000_0000;
      if (apb.paddr == `PLS_CFG_OFS) begin
         rd_word[`PLS_CFG_MSB:0] = cfg;
      end else if (apb.paddr == `PLS_PRESET_OFS) begin
         rd_word[`PLS_PRESET_MSB:0] = preset;
      end else if (apb.paddr == `PLS_STATUS_OFS) begin
         rd_word[15:0]              = {out_reg, state};
         rd_word[`PLS_ST_PD_BIT]    = pd_active;
         rd_word[`PLS_ST_LOCKA_BIT] = locked[0];
         rd_word[`PLS_ST_LOCKB_BIT] = locked[1];
      end else if (pls_is_term(apb.paddr)) begin
         unique case (apb.paddr[3:2])
            `PLS_WORD_TRUE: begin
               rd_word[`PLS_FEEDS_C_BIT]  = terms[idx].feeds_c;
               rd_word[`PLS_LINK_MSB:0]   = terms[idx].t;
            end
            `PLS_WORD_COMP: begin
               rd_word[`PLS_LINK_MSB:0]   = terms[idx].c;
            end
            default: begin
               rd_word = {terms[idx].j_st, terms[idx].k_st,
                          terms[idx].j_out, terms[idx].k_out};
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready <= apb.psel & apb.penable & ~pready;
         if (apb.psel && apb.penable && !pready) begin
            prdata  <= apb.pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= ~pls_addr_ok(apb.paddr);
         end
      end
   end

   // Options default low, as an unprogrammed part
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg    <= `PLS_CFG_RST;
         preset <= `PLS_PRESET_RST;
      end else if (wr_en) begin
         if (apb.paddr == `PLS_CFG_OFS) begin
            cfg <= apb.pwdata[`PLS_CFG_MSB:0];
         end
         if (apb.paddr == `PLS_PRESET_OFS) begin
            preset <= apb.pwdata[`PLS_PRESET_MSB:0];
         end
      end
   end

   // Links start intact, so every term is inactive until programmed
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `PLS_NUM_TERMS; i++) begin
            terms[i] <= '1;
         end
      end else if (wr_en && pls_is_term(apb.paddr)) begin
         unique case (apb.paddr[3:2])
            `PLS_WORD_TRUE: begin
               terms[idx].feeds_c <= apb.pwdata[`PLS_FEEDS_C_BIT];
               terms[idx].t       <= apb.pwdata[`PLS_LINK_MSB:0];
            end
            `PLS_WORD_COMP: begin
               terms[idx].c <= apb.pwdata[`PLS_LINK_MSB:0];
            end
            default: begin
               {terms[idx].j_st, terms[idx].k_st,
                terms[idx].j_out, terms[idx].k_out} <= apb.pwdata;
            end
         endcase
      end
   end

   chk_power_up_high: assert property (@(posedge ref_clk) disable iff (rst)
      $past(rst) |-> state == 8'hFF && out_reg == 8'hFF)
      else $error("registers not all high after reset");

   chk_pd_outputs_off: assert property (@(posedge ref_clk) disable iff (rst)
      pd_active |=> f_oe == 8'h00)
      else $error("outputs driven while powered down");

   chk_pd_hold_regs: assert property (@(posedge ref_clk) disable iff (rst)
      pd_active |=> $stable(state) && $stable(out_reg))
      else $error("register changed while powered down");

   chk_pd_release: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(pd_active) && !sv_load_state && !sv_load_out && oe_off == 2'b00
      |=> f_oe == 8'hFF
      && ($past(sv_diag_show) ? f_out == $past(state) : f_out == $past(out_reg)))
      else $error("outputs not restored after power up");

   chk_in16_removed: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.pin_mode == PLS_PIN_PWRDN |-> vars.in[16] == 1'b0)
      else $error("input 16 reached array in power-down mode");

   chk_init_preset: assert property (@(posedge ref_clk) disable iff (rst)
      init[0] && !pd_active |=> state[3:0] == $past(preset[3:0])
      && out_reg[3:0] == $past(preset[11:8]))
      else $error("group a not forced to preset");

   chk_oe_group_b: assert property (@(posedge ref_clk) disable iff (rst)
      oe_off[1] && !oe_off[0] && !pd_active && !sv_load_state && !sv_load_out
      |=> f_oe == 8'h0F)
      else $error("group b enable not honoured");

   chk_diag_show: assert property (@(posedge ref_clk) disable iff (rst)
      sv_diag_show |=> f_out == $past(state))
      else $error("outputs do not show state register");

   chk_load_state: assert property (@(posedge ref_clk) disable iff (rst)
      sv_load_state && clk_valid == 2'b11 && init == 2'b00 && !pd_active
      |=> state == $past(f_in) && $stable(out_reg) && f_oe == 8'h00)
      else $error("state register not loaded from pins");

   chk_clock_load: assert property (@(posedge ref_clk) disable iff (rst)
      clk_valid[1] && !init[1] && !pd_active && !sv_load_state && !sv_load_out
      |=> out_reg[7:4] == $past(next_out[7:4]) ##1 f_out[7:4] == $past(out_reg[7:4])
      || $past(sv_diag_show))
      else $error("output register not loaded on clock edge");
endmodule

// File: rtl/pls_grp.sv
`timescale 1ns/10ps
module pls_grp (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic pin_init,
   input  wire logic term_init,
   input  wire logic term_init_en,
   input  wire logic pin_oe,
   input  wire logic term_oe,
   input  wire logic term_oe_en,
   input  wire logic clk_rise,
   input  wire logic clk_fall,
   input  wire logic hold,
   output logic      init,
   output logic      oe_off,
   output logic      clk_valid,
   output logic      locked
);
   import pls_pkg::*;

   // Term control, once enabled, shuts the pin out entirely
   assign init      = term_init_en ? term_init : pin_init;
   assign oe_off    = term_oe_en ? term_oe : pin_oe;
   assign clk_valid = clk_rise & ~locked & ~init & ~hold;

   // Starts locked: the first reliable edge follows a falling clock
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         locked <= 1'b1;
      end else if (init) begin
         locked <= 1'b1;
      end else if (clk_fall) begin
         locked <= 1'b0;
      end
   end

   chk_lock_blocks: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(init) ##0 !clk_fall |-> !clk_valid && locked)
      else $error("clock taken before falling edge after init");

   chk_term_over_pin: assert property (@(posedge ref_clk) disable iff (rst)
      term_init_en && !term_init |-> !init)
      else $error("pin init not ignored under term control");
endmodule

// File: rtl/pls_pkg.sv
package pls_pkg;
`include "pls_regs.svh"

   typedef enum logic [1:0] {
      PLS_PIN_INPUT = 2'h0,
      PLS_PIN_PWRDN = 2'h1,
      PLS_PIN_INIT  = 2'h2,
      PLS_PIN_OE    = 2'h3
   } pls_pin_mode_t;

   typedef struct packed {
      logic          clock_source_choice;
      logic          oe_term_en_b;
      logic          oe_term_en_a;
      logic          init_term_en_b;
      logic          init_term_en_a;
      pls_pin_mode_t pin_mode;
   } pls_cfg_t;

   // One array variable set: complement bit, state bits, logic inputs
   typedef struct packed {
      logic        c;
      logic [7:0]  st;
      logic [16:0] in;
   } pls_vars_t;

   // A link bit of 1 means the connection is intact
   typedef struct packed {
      logic       feeds_c;
      pls_vars_t  t;
      pls_vars_t  c;
      logic [7:0] j_st;
      logic [7:0] k_st;
      logic [7:0] j_out;
      logic [7:0] k_out;
   } pls_term_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pls_apb_req_t;

   // Term is true only if every variable satisfies its links
   function automatic logic pls_hit(input pls_vars_t t, input pls_vars_t c,
                                    input pls_vars_t v);
      return &(~(t & c) & (~t | v) & (~c | ~v));
   endfunction

   function automatic logic pls_jk(input logic q, input logic j, input logic k);
      return (j & ~q) | (~k & q);
   endfunction

   function automatic logic pls_is_term(input logic [11:0] a);
      return (a >= `PLS_TERM_BASE) && (a <= `PLS_TERM_LAST) && (a[3:2] != 2'h3);
   endfunction

   function automatic logic [6:0] pls_term_idx(input logic [11:0] a);
      logic [11:0] d;
      d = a - `PLS_TERM_BASE;
      return d[10:4];
   endfunction

   function automatic logic pls_addr_ok(input logic [11:0] a);
      return (a == `PLS_CFG_OFS) || (a == `PLS_PRESET_OFS) || (a == `PLS_STATUS_OFS)
             || pls_is_term(a);
   endfunction
endpackage

// File: rtl/pls_regs.svh
`ifndef PLS_REGS_SVH
`define PLS_REGS_SVH
// Register byte offsets
`define PLS_CFG_OFS        12'h000
`define PLS_PRESET_OFS     12'h004
`define PLS_STATUS_OFS     12'h008
`define PLS_TERM_BASE      12'h100
`define PLS_TERM_LAST      12'h57C
// Term table: 68 logic terms then the four control terms
`define PLS_NUM_TERMS      72
`define PLS_TERM_INA       68
`define PLS_TERM_INB       69
`define PLS_TERM_OEA       70
`define PLS_TERM_OEB       71
// Term word selects (paddr[3:2])
`define PLS_WORD_TRUE      2'h0
`define PLS_WORD_COMP      2'h1
`define PLS_WORD_JK        2'h2
// Field positions
`define PLS_CFG_MSB        6
`define PLS_FEEDS_C_BIT    26
`define PLS_LINK_MSB       25
`define PLS_PRESET_MSB     15
`define PLS_ST_PD_BIT      16
`define PLS_ST_LOCKA_BIT   17
`define PLS_ST_LOCKB_BIT   18
// Reset values
`define PLS_CFG_RST        7'h00
`define PLS_PRESET_RST     16'h0000
`define PLS_REGS_RST       8'hFF
`endif

// File: testbench/pls_ext_logic.sv
`timescale 1ns/10ps
module pls_ext_logic (
   input  wire logic   ref_clk,
   output logic        seq_clk,
   output logic        ctl_pin,
   output logic [15:0] logic_in,
   output logic [2:0]  sv_sel,
   output logic [7:0]  pin_drv
);
   logic       jam_en;
   logic [7:0] jam_val;
   logic [7:0] wobble;
   initial begin
      seq_clk = 1'b0;
      ctl_pin = 1'b0;
      logic_in = 16'h0000;
      sv_sel = 3'h0;
      jam_en = 1'b0;
      jam_val = 8'h00;
      wobble = 8'h00;
   end
   // Released pins show a changing pattern so no stale value passes
   always @(posedge ref_clk) begin
      wobble <= ~wobble;
   end
   assign pin_drv = jam_en ? jam_val : wobble;
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Clock only issued once control levels have settled
   task automatic pulse();
      @(posedge ref_clk);
      seq_clk <= 1'b1;
      step(2);
      seq_clk <= 1'b0;
      step(2);
   endtask
   task automatic set_ctl(input logic v);
      @(posedge ref_clk);
      ctl_pin <= v;
      step(3);
   endtask
   task automatic set_in(input logic [15:0] v);
      @(posedge ref_clk);
      logic_in <= v;
      step(3);
   endtask
   task automatic set_sv(input logic [2:0] v);
      @(posedge ref_clk);
      sv_sel <= v;
      step(3);
   endtask
   task automatic jam(input logic en, input logic [7:0] v);
      @(posedge ref_clk);
      jam_en <= en;
      jam_val <= v;
      step(3);
   endtask
   task automatic wiggle();
      repeat (4) begin
         @(posedge ref_clk);
         logic_in <= ~logic_in;
      end
   endtask
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/10ps
`include "pls_regs.svh"
module tb_top;
   import pls_pkg::*;
   logic         ref_clk;
   logic         rst;
   pls_apb_req_t apb;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         seq_clk;
   logic         ctl_pin;
   logic [15:0]  logic_in;
   logic [2:0]   sv_sel;
   logic [7:0]   pin_drv;
   logic [7:0]   f_in;
   logic [7:0]   f_out;
   logic [7:0]   f_oe;
   logic [31:0]  rd;
   logic         err;
   int           error_cnt;
   int           n_tests;
   assign f_in = (f_out & f_oe) | (pin_drv & ~f_oe);
   pls_core pls_core_inst (
      .ref_clk(ref_clk), .rst(rst), .apb(apb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .logic_in(logic_in), .seq_clk(seq_clk), .ctl_pin(ctl_pin),
      .sv_diag_show(sv_sel[2]), .sv_load_state(sv_sel[1]), .sv_load_out(sv_sel[0]),
      .f_in(f_in), .f_out(f_out), .f_oe(f_oe)
   );
   pls_ext_logic ext_inst (
      .ref_clk(ref_clk), .seq_clk(seq_clk), .ctl_pin(ctl_pin), .logic_in(logic_in),
      .sv_sel(sv_sel), .pin_drv(pin_drv)
   );
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge ref_clk);
      apb.penable <= 1'b1;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         error_cnt++;
         complete_run();
      end else begin
         rd = prdata;
         err = pslverr;
         apb <= '0;
      end
   endtask
   task automatic term(input int n, input logic [31:0] w0, w1, w2);
      xfer(1'b1, `PLS_TERM_BASE + 12'(16 * n), w0);
      xfer(1'b1, `PLS_TERM_BASE + 12'(16 * n) + 12'h004, w1);
      xfer(1'b1, `PLS_TERM_BASE + 12'(16 * n) + 12'h008, w2);
   endtask
   task automatic status(input logic [31:0] msk, input logic [31:0] exp);
      xfer(1'b0, `PLS_STATUS_OFS, 32'h0000_0000);
      chk(rd & msk, exp);
   endtask
   task automatic oe_is(input logic [7:0] v);
      ext_inst.step(3);
      chk(32'(f_oe), 32'(v));
   endtask
   task automatic s_reset();
      status(32'hFFFF_FFFF, 32'h0006_FFFF);
      chk(32'(f_out), 32'h0000_00FF);
      oe_is(8'hFF);
      xfer(1'b0, `PLS_CFG_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      xfer(1'b0, `PLS_TERM_BASE + 12'h004, 32'h0000_0000);
      chk(rd, 32'h03FF_FFFF);
      xfer(1'b0, `PLS_TERM_BASE + 12'h00C, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001);
   endtask
   task automatic s_clock();
      // Input 5 and complement links left unconnected
      term(0, 32'h0000_0000, 32'h0000_0000, 32'h0101_0101);
      term(1, 32'h0000_0001, 32'h0000_0001, 32'h0000_00F0);
      ext_inst.pulse();
      status(32'hFFFF_FFFF, 32'h0000_FFFF);
      ext_inst.pulse();
      status(32'hFFFF_FFFF, 32'h0000_FEFE);
      chk(32'(f_out), 32'h0000_00FE);
   endtask
   task automatic s_init();
      xfer(1'b1, `PLS_PRESET_OFS, 32'h0000_C35A);
      xfer(1'b1, `PLS_CFG_OFS, 32'h0000_0002);
      ext_inst.set_ctl(1'b1);
      status(32'h0001_FFFF, 32'h0000_C35A);
      chk(32'(f_out), 32'h0000_00C3);
      ext_inst.pulse();
      status(32'h0001_FFFF, 32'h0000_C35A);
      ext_inst.set_ctl(1'b0);
      ext_inst.pulse();
      status(32'h0001_FFFF, 32'h0000_C35A);
      ext_inst.pulse();
      status(32'h0001_FFFF, 32'h0000_C25B);
   endtask
   task automatic s_oe();
      xfer(1'b1, `PLS_CFG_OFS, 32'h0000_0003);
      ext_inst.set_ctl(1'b1);
      oe_is(8'h00);
      ext_inst.set_ctl(1'b0);
      oe_is(8'hFF);
      // Diagnostic inputs kept out of the control term
      term(70, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
      xfer(1'b1, `PLS_CFG_OFS, 32'h0000_0013);
      oe_is(8'hF0);
      ext_inst.set_ctl(1'b1);
      oe_is(8'h00);
      term(70, 32'h03FF_FFFF, 32'h03FF_FFFF, 32'h0000_0000);
      oe_is(8'h0F);
      ext_inst.set_ctl(1'b0);
   endtask
   task automatic s_pd();
      xfer(1'b1, `PLS_CFG_OFS, 32'h0000_0001);
      ext_inst.set_ctl(1'b1);
      oe_is(8'h00);
      ext_inst.pulse();
      ext_inst.wiggle();
      ext_inst.pulse();
      status(32'h0001_FFFF, 32'h0001_C25B);
      ext_inst.set_ctl(1'b0);
      oe_is(8'hFF);
      chk(32'(f_out), 32'h0000_00C2);
   endtask
   task automatic s_diag();
      xfer(1'b1, `PLS_CFG_OFS, 32'h0000_0000);
      ext_inst.set_sv(3'b100);
      chk(32'(f_out), 32'h0000_005B);
      ext_inst.set_sv(3'b000);
      chk(32'(f_out), 32'h0000_00C2);
      ext_inst.set_sv(3'b010);
      ext_inst.jam(1'b1, 8'h3C);
      ext_inst.pulse();
      ext_inst.pulse();
      status(32'h0000_FFFF, 32'h0000_C23C);
      ext_inst.set_sv(3'b001);
      ext_inst.jam(1'b1, 8'h81);
      ext_inst.pulse();
      ext_inst.pulse();
      status(32'h0000_FFFF, 32'h0000_813C);
      ext_inst.jam(1'b0, 8'h00);
      ext_inst.set_sv(3'b000);
   endtask
   task automatic s_array();
      // Complement fed by input 3; input 5 left unconnected
      term(2, 32'h0400_0008, 32'h0000_0000, 32'h0000_0000);
      term(3, 32'h0200_0000, 32'h0000_0000, 32'h8000_0000);
      term(4, 32'h0001_0000, 32'h0000_0000, 32'h0000_4040);
      ext_inst.set_in(16'h0008);
      ext_inst.pulse();
      status(32'h0000_FFFF, 32'h0000_803D);
      ext_inst.set_in(16'h0000);
      ext_inst.pulse();
      status(32'h0000_FFFF, 32'h0000_81BC);
      ext_inst.set_ctl(1'b1);
      ext_inst.pulse();
      status(32'h0000_FFFF, 32'h0000_C0BD);
      ext_inst.set_ctl(1'b0);
      xfer(1'b1, `PLS_CFG_OFS, 32'h0000_0001);
      ext_inst.pulse();
      status(32'h0001_FFFF, 32'h0000_81BC);
      // Second clock on input 5: the plain clock pin no longer counts
      xfer(1'b1, `PLS_CFG_OFS, 32'h0000_0041);
      ext_inst.pulse();
      status(32'h0000_FFFF, 32'h0000_81BC);
      ext_inst.set_in(16'h0020);
      ext_inst.set_in(16'h0000);
      status(32'h0000_FFFF, 32'h0000_C0BD);
      term(68, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
      xfer(1'b1, `PLS_CFG_OFS, 32'h0000_0006);
      status(32'h0006_FFFF, 32'h0002_C3BA);
      ext_inst.set_ctl(1'b1);
      term(68, 32'h03FF_FFFF, 32'h03FF_FFFF, 32'h0000_0000);
      status(32'h0006_FFFF, 32'h0006_C35A);
      ext_inst.pulse();
      ext_inst.pulse();
      status(32'h0006_FFFF, 32'h0004_C25B);
      ext_inst.set_ctl(1'b0);
      xfer(1'b1, `PLS_CFG_OFS, 32'h0000_0000);
   endtask
   task automatic s_rerun();
      @(posedge ref_clk);
      rst <= 1'b1;
      ext_inst.step(5);
      rst <= 1'b0;
      status(32'hFFFF_FFFF, 32'h0006_FFFF);
      xfer(1'b0, `PLS_TERM_BASE + 12'h020, 32'h0000_0000);
      chk(rd, 32'h07FF_FFFF);
   endtask
   initial begin
      rst = 1'b1;
      apb = '0;
      error_cnt = 0;
      n_tests = 0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      s_reset();
      s_clock();
      s_init();
      s_oe();
      s_pd();
      s_diag();
      s_array();
      s_rerun();
      complete_run();
   end
endmodule
